// >>> smsx_pkg.sv
package smsx_pkg;
  // Character width and bit counter width
  localparam int unsigned CHAR_BITS = 8;
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h8;
  // Bit-rate dividers: half-period in system clocks per rate select
  localparam int unsigned DIV_W = 6;
  localparam logic [5:0] HALF_DIV0 = 6'h01;
  localparam logic [5:0] HALF_DIV1 = 6'h02;
  localparam logic [5:0] HALF_DIV2 = 6'h08;
  localparam logic [5:0] HALF_DIV3 = 6'h10;
  localparam logic [5:0] DIV_ONE = 6'h01;
  localparam logic [5:0] DIV_ZERO = 6'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Master sequencer states
  typedef enum logic [2:0] {
    SMSX_IDLE = 3'h1,
    SMSX_LEAD = 3'h2,
    SMSX_TRAIL = 3'h4
  } smsx_state_type;
endpackage

// >>> smsx_rate_div.sv
`timescale 1ns/1ps
// Half-period tick generator for the master serial clock
module smsx_rate_div (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  input wire logic [1:0] rate_sel_i,
  // Tick
  output logic tick_o
);
  typedef struct packed {
    logic [smsx_pkg::DIV_W-1:0] cnt;
  } smsx_div_type;
  smsx_div_type div_r;
  smsx_div_type div_nxt;
  logic [smsx_pkg::DIV_W-1:0] limit;

  always_comb begin
    case (rate_sel_i)
      2'h0: limit = smsx_pkg::HALF_DIV0;
      2'h1: limit = smsx_pkg::HALF_DIV1;
      2'h2: limit = smsx_pkg::HALF_DIV2;
      default: limit = smsx_pkg::HALF_DIV3;
    endcase
  end

  always_comb begin
    div_nxt = div_r;
    if (!run_i) begin
      div_nxt.cnt = smsx_pkg::DIV_ZERO;
    end else if (div_r.cnt + smsx_pkg::DIV_ONE >= limit) begin
      div_nxt.cnt = smsx_pkg::DIV_ZERO;
    end else begin
      div_nxt.cnt = div_r.cnt + smsx_pkg::DIV_ONE;
    end
  end

  // Tick as a comb pulse keeps the phase exact when the count wraps
  assign tick_o = run_i && (div_r.cnt + smsx_pkg::DIV_ONE >= limit);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      div_r <= '{cnt: smsx_pkg::DIV_ZERO};
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule // smsx_rate_div

// >>> smsx_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Shift out and in simultaneously per transfer
// - Works as clock master or slave
// - Polarity selects serial clock idle level
// - Phase selects launch and sample edges
// - Settings should match; change between transfers
// - Phase-0 slave write while selected collides
// - Phase-1 slave accepts back-to-back with select low
// - Unselected slave leaves bus alone
// - Exactly eight bits exchanged per transfer
// - Single transmit buffer, no load mid-transfer
// - Received byte copied to read buffer
// - Overrun only if buffer unread at next
// - One data port: read buffer, write shifter
// - Master rate from four selectable settings
// - Write during transfer flags collision
// - Mode fault disables serial output drivers
// - Master emits exactly eight clock cycles
// - Launch on one edge, sample opposite
// - Unselected slave ignores clock, output floating
module smsx_core (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic master_i,
  input wire logic clock_idle_level_select_i,
  input wire logic clock_edge_format_select_i,
  input wire logic [1:0] rate_sel_i,
  input wire logic fault_detect_en_i,
  // Data port
  input wire logic serial_data_port_wr_i,
  input wire logic [7:0] serial_data_port_wdata_i,
  input wire logic serial_data_port_rd_i,
  output logic [7:0] serial_data_port_rdata_o,
  // Status
  output logic done_o,
  output logic busy_o,
  output logic write_collision_o,
  output logic overrun_o,
  output logic mode_fault_o,
  input wire logic status_clear_i,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i
);
  typedef struct packed {
    smsx_pkg::smsx_state_type state;
    logic [7:0] shift;
    logic [7:0] rbuf;
    logic rbuf_full;
    logic [smsx_pkg::CNT_W-1:0] cnt;
    logic sck_lvl;
    logic sck_prev;
    logic in_bit;
    logic out_bit;
    logic done;
    logic wcol;
    logic ovr;
    logic modf;
  } smsx_core_type;

  smsx_core_type st_r;
  smsx_core_type st_nxt;
  logic tick;
  logic run;
  logic sck_edge;
  logic lead_edge;
  logic slave_sel;
  logic byte_end;
  logic [7:0] rx_byte;

  assign run = enable_i && master_i && !st_r.modf && (st_r.state != smsx_pkg::SMSX_IDLE);

  smsx_rate_div #() u_div (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .run_i(run),
    .rate_sel_i(rate_sel_i),
    .tick_o(tick)
  );

  assign slave_sel = enable_i && !master_i && !ss_n_i;
  // Slave edges come from the sampled serial clock; leading edge leaves idle level
  assign sck_edge = slave_sel && (sck_i != st_r.sck_prev);
  assign lead_edge = sck_edge && (st_r.sck_prev == clock_idle_level_select_i);

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    byte_end = 1'b0;
    rx_byte = {st_r.shift[6:0], st_r.in_bit};
    st_nxt.sck_prev = sck_i;
    if (master_i && fault_detect_en_i && enable_i && !ss_n_i) begin
      st_nxt.modf = 1'b1;
      st_nxt.state = smsx_pkg::SMSX_IDLE;
      st_nxt.cnt = smsx_pkg::CNT_ZERO;
    end
    // An idle master follows the polarity too, so a new setting shows before the next byte
    if (!enable_i || !master_i || (st_r.state == smsx_pkg::SMSX_IDLE)) begin
      st_nxt.sck_lvl = clock_idle_level_select_i;
    end
    if (serial_data_port_wr_i && enable_i) begin
      // Busy shifter or selected phase-0 slave refuses the write
      if ((st_r.cnt != smsx_pkg::CNT_ZERO) || (st_r.state != smsx_pkg::SMSX_IDLE)
          || (slave_sel && !clock_edge_format_select_i)) begin
        st_nxt.wcol = 1'b1;
      end else begin
        st_nxt.shift = serial_data_port_wdata_i;
        st_nxt.out_bit = serial_data_port_wdata_i[7];
        if (master_i && !st_r.modf) begin
          st_nxt.state = smsx_pkg::SMSX_LEAD;
          st_nxt.cnt = smsx_pkg::CNT_ZERO;
          st_nxt.out_bit = serial_data_port_wdata_i[7];
        end
      end
    end
    case (st_r.state)
      smsx_pkg::SMSX_IDLE: begin
        // Slave side: count edges of the incoming clock
        if (sck_edge) begin
          if (lead_edge == !clock_edge_format_select_i) begin
            st_nxt.in_bit = master_i ? miso_i : mosi_i;
            if (st_r.cnt == smsx_pkg::CNT_ZERO && clock_edge_format_select_i) begin
              st_nxt.cnt = smsx_pkg::CNT_ONE;
            end
            if (!clock_edge_format_select_i) begin
              st_nxt.shift = rx_byte;
              st_nxt.shift[0] = mosi_i;
              st_nxt.cnt = st_r.cnt + smsx_pkg::CNT_ONE;
              byte_end = (st_r.cnt + smsx_pkg::CNT_ONE) == smsx_pkg::CNT_LAST;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], mosi_i};
              byte_end = st_r.cnt == smsx_pkg::CNT_LAST;
            end
          end else begin
            if (clock_edge_format_select_i) begin
              // Phase 1 launches on leading edge
              st_nxt.out_bit = st_r.shift[7];
              if (st_r.cnt == smsx_pkg::CNT_ZERO) begin
                st_nxt.cnt = smsx_pkg::CNT_ONE;
              end else begin
                st_nxt.cnt = st_r.cnt + smsx_pkg::CNT_ONE;
              end
            end else begin
              st_nxt.out_bit = st_r.shift[7];
            end
          end
        end
        if (!slave_sel && !master_i) begin
          // Byte count restarts whenever the slave is deselected, in phase 0 and phase 1 alike
          st_nxt.cnt = smsx_pkg::CNT_ZERO;
          st_nxt.out_bit = st_r.shift[7];
        end
      end
      smsx_pkg::SMSX_LEAD: begin
        if (tick) begin
          st_nxt.sck_lvl = !st_r.sck_lvl;
          st_nxt.state = smsx_pkg::SMSX_TRAIL;
          if (clock_edge_format_select_i) begin
            if (st_r.cnt != smsx_pkg::CNT_ZERO) begin
              st_nxt.shift = {st_r.shift[6:0], st_r.in_bit};
            end
            st_nxt.out_bit = (st_r.cnt != smsx_pkg::CNT_ZERO) ? st_r.shift[6] : st_r.shift[7];
          end else begin
            st_nxt.in_bit = miso_i;
          end
        end
      end
      smsx_pkg::SMSX_TRAIL: begin
        if (tick) begin
          st_nxt.sck_lvl = !st_r.sck_lvl;
          st_nxt.cnt = st_r.cnt + smsx_pkg::CNT_ONE;
          if (clock_edge_format_select_i) begin
            st_nxt.in_bit = miso_i;
          end else begin
            st_nxt.shift = rx_byte;
            st_nxt.out_bit = st_r.shift[6];
          end
          if ((st_r.cnt + smsx_pkg::CNT_ONE) == smsx_pkg::CNT_LAST) begin
            st_nxt.state = smsx_pkg::SMSX_IDLE;
            st_nxt.cnt = smsx_pkg::CNT_ZERO;
            byte_end = 1'b1;
            if (clock_edge_format_select_i) begin
              rx_byte = {st_r.shift[6:0], miso_i};
              st_nxt.shift = rx_byte;
            end
          end else begin
            st_nxt.state = smsx_pkg::SMSX_LEAD;
          end
        end
      end
      default: begin
        st_nxt.state = smsx_pkg::SMSX_IDLE;
      end
    endcase
    if (byte_end) begin
      if (master_i) begin
        rx_byte = st_nxt.shift;
      end else begin
        rx_byte = st_nxt.shift;
        st_nxt.cnt = smsx_pkg::CNT_ZERO;
      end
      // Set wins over a read in the same cycle
      st_nxt.rbuf = rx_byte;
      st_nxt.done = 1'b1;
      if (st_r.rbuf_full && !serial_data_port_rd_i) begin
        st_nxt.ovr = 1'b1;
      end else begin
        st_nxt.rbuf_full = 1'b1;
      end
    end else if (serial_data_port_rd_i) begin
      st_nxt.rbuf_full = 1'b0;
    end
    if (status_clear_i) begin
      st_nxt.wcol = st_nxt.wcol && !st_r.wcol ? 1'b1 : (st_nxt.wcol & ~st_r.wcol);
      st_nxt.ovr = (st_nxt.ovr && !st_r.ovr);
      st_nxt.modf = (st_nxt.modf && !st_r.modf) ||
        (master_i && fault_detect_en_i && enable_i && !ss_n_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_r <= '{state: smsx_pkg::SMSX_IDLE, shift: smsx_pkg::BYTE_ZERO,
                rbuf: smsx_pkg::BYTE_ZERO, rbuf_full: 1'b0, cnt: smsx_pkg::CNT_ZERO,
                sck_lvl: 1'b0, sck_prev: 1'b0, in_bit: 1'b0, out_bit: 1'b0,
                done: 1'b0, wcol: 1'b0, ovr: 1'b0, modf: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs: drivers released on mode fault and for an unselected slave
  assign serial_data_port_rdata_o = st_r.rbuf;
  assign done_o = st_r.done;
  assign busy_o = (st_r.state != smsx_pkg::SMSX_IDLE) || (st_r.cnt != smsx_pkg::CNT_ZERO);
  assign write_collision_o = st_r.wcol;
  assign overrun_o = st_r.ovr;
  assign mode_fault_o = st_r.modf;
  assign sck_o = st_r.sck_lvl;
  assign sck_oe_o = enable_i && master_i && !st_r.modf;
  assign mosi_o = st_r.out_bit;
  assign mosi_oe_o = enable_i && master_i && !st_r.modf;
  assign miso_o = st_r.out_bit;
  assign miso_oe_o = slave_sel;
endmodule // smsx_core

// >>> smsx_chk.sv
`timescale 1ns/1ps
module smsx_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic enable_i,
  input wire logic master_i,
  input wire logic clock_idle_level_select_i,
  input wire logic clock_edge_format_select_i,
  input wire logic fault_detect_en_i,
  input wire logic serial_data_port_wr_i,
  input wire logic status_clear_i,
  input wire logic ss_n_i,
  input wire logic done_o,
  input wire logic busy_o,
  input wire logic write_collision_o,
  input wire logic mode_fault_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [4:0] tgl_r;
  // Restarts as busy rises, so idle polarity changes never leak into a count
  always_ff @(posedge clock_i) begin
    if ($rose(busy_o)) tgl_r <= 5'h00;
    else if (sck_o != $past(sck_o)) tgl_r <= tgl_r + 5'h01;
  end
  chk_done_one_cycle: assert property (done_o |=> !done_o)
    else $error("done held too long");
  chk_eight_sck_cycles: assert property (
    $fell(busy_o) && master_i && !mode_fault_o |=> tgl_r == 5'h10)
    else $error("serial clock edge count wrong");
  chk_busy_write_collide: assert property (
    busy_o && enable_i && serial_data_port_wr_i |=> write_collision_o)
    else $error("write during transfer not flagged");
  chk_phase0_collide: assert property (
    !master_i && !clock_edge_format_select_i && !ss_n_i && !$past(ss_n_i)
    && !$past(ss_n_i, 2) && enable_i && serial_data_port_wr_i |=> write_collision_o)
    else $error("selected slave write not flagged");
  chk_collide_sticky: assert property (
    write_collision_o && !status_clear_i |=> write_collision_o)
    else $error("collision flag lost");
  chk_fault_releases: assert property (mode_fault_o |-> !sck_oe_o && !mosi_oe_o)
    else $error("drivers on during mode fault");
  chk_fault_raised: assert property (
    master_i && enable_i && fault_detect_en_i && !ss_n_i && !$past(ss_n_i)
    |-> ##[0:3] mode_fault_o)
    else $error("mode fault missed");
  chk_unselected_float: assert property (
    !master_i && ss_n_i && $past(ss_n_i) && $past(ss_n_i, 2) |-> !miso_oe_o)
    else $error("unselected slave drives data");
  chk_sck_idle_level: assert property (
    master_i && $past(master_i) && enable_i && $past(enable_i) && $past(nrst_i) && !busy_o
    && !$past(busy_o) && $stable(clock_idle_level_select_i)
    |-> sck_o == clock_idle_level_select_i)
    else $error("serial clock not at idle level");
endmodule // smsx_chk

// >>> smsx_peer.sv
`timescale 1ns/1ps
// Selected peripheral; reacts on clock edges with no delay, like a plain shifter
module smsx_peer (
  // Format and load
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  // Serial lines
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [7:0] sh_o
);
  wire logic k = sck_i ^ pol_i;
  always @(posedge load_i or posedge k or negedge k) begin
    if (load_i) begin
      sh_o <= tx_i;
      miso_o <= tx_i[7];
    end else if (k == pha_i) miso_o <= sh_o[7];
    else sh_o <= {sh_o[6:0], mosi_i};
  end
endmodule // smsx_peer

// >>> smsx_core_tb.sv
`timescale 1ns/1ps
module smsx_core_tb;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic master_i = 1'b1;
  logic pol = 1'b0;
  logic pha = 1'b0;
  logic [1:0] rate = 2'h0;
  logic fden = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b0;
  logic ss_n = 1'b1;
  logic tsck = 1'b0;
  logic tmosi = 1'b0;
  logic load = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ptx = 8'h00;
  logic [7:0] rdata, prx, q;
  logic done, busy, wcol, ovr, mf, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
  int error_cnt = 0;
  int n_checks = 0;
  wire logic sck_w = master_i ? sck_o : tsck;
  wire logic mosi_w = master_i ? mosi_o : tmosi;
  // A released slave output shows the inverse, never a stale level
  wire logic miso_w = master_i ? pmiso : (miso_oe ? miso_o : ~miso_o);
  smsx_core dut (.clock_i(clock_i), .nrst_i(nrst_i), .enable_i(1'b1), .master_i(master_i),
    .clock_idle_level_select_i(pol), .clock_edge_format_select_i(pha), .rate_sel_i(rate),
    .fault_detect_en_i(fden), .serial_data_port_wr_i(wr), .serial_data_port_wdata_i(wdata),
    .serial_data_port_rd_i(rd), .serial_data_port_rdata_o(rdata), .done_o(done),
    .busy_o(busy), .write_collision_o(wcol), .overrun_o(ovr), .mode_fault_o(mf),
    .status_clear_i(clr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe), .ss_n_i(ss_n));
  smsx_peer peer (.pol_i(pol), .pha_i(pha), .load_i(load), .tx_i(ptx), .sck_i(sck_w),
    .mosi_i(mosi_w), .miso_o(pmiso), .sh_o(prx));
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic write(input logic [7:0] d, input logic ld);
    @(posedge clock_i) wr <= 1'b1;
    wdata <= d;
    load <= ld;
    @(posedge clock_i) wr <= 1'b0;
    load <= 1'b0;
  endtask
  task automatic read(input logic [7:0] exp);
    chk(rdata, exp);
    @(posedge clock_i) rd <= 1'b1;
    @(posedge clock_i) rd <= 1'b0;
  endtask
  task automatic clear;
    @(posedge clock_i) clr <= 1'b1;
    @(posedge clock_i) clr <= 1'b0;
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    do begin
      @(negedge clock_i);
      i++;
    end while (done !== 1'b1 && i < 600);
    if (i == 600) error_cnt++;
  endtask
  // Bench as master; sampling late in the high phase suits both formats
  task automatic sl_xfer(input logic [7:0] d, output logic [7:0] r);
    @(posedge clock_i) ss_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      @(posedge clock_i) tmosi <= d[b];
      cyc(4);
      tsck <= 1'b1;
      cyc(6);
      @(negedge clock_i) r[b] = miso_w;
      @(posedge clock_i) tsck <= 1'b0;
    end
    cyc(6);
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    cyc(12);
    nrst_i <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clock_i) {pol, pha} <= m[1:0];
      rate <= m[1:0];
      ptx <= 8'hA5 ^ m[7:0];
      cyc(4);
      write(8'h3C + m[7:0], 1'b1);
      wait_done;
      read(8'hA5 ^ m[7:0]);
      chk(prx, 8'h3C + m[7:0]);
    end
    chk({7'h00, ovr}, 8'h00);
    ptx <= 8'h11;
    write(8'hC3, 1'b1);
    write(8'h24, 1'b0);
    @(negedge clock_i) chk({7'h00, wcol}, 8'h01);
    wait_done;
    read(8'h11);
    chk(prx, 8'hC3);
    clear;
    write(8'h5A, 1'b1);
    wait_done;
    ptx <= 8'h77;
    write(8'hA6, 1'b1);
    wait_done;
    cyc(2);
    chk({7'h00, ovr}, 8'h01);
    read(8'h77);
    fden <= 1'b1;
    ss_n <= 1'b0;
    write(8'hF0, 1'b1);
    cyc(4);
    @(negedge clock_i) chk({5'h00, mf, sck_oe, mosi_oe}, 8'h04);
    @(posedge clock_i) ss_n <= 1'b1;
    fden <= 1'b0;
    clear;
    @(posedge clock_i) master_i <= 1'b0;
    {pol, pha} <= 2'h0;
    cyc(3);
    @(negedge clock_i) chk({7'h00, miso_oe}, 8'h00);
    write(8'h96, 1'b0);
    sl_xfer(8'h5A, q);
    chk(q, 8'h96);
    read(8'h5A);
    cyc(2);
    write(8'h33, 1'b0);
    @(negedge clock_i) chk({7'h00, wcol}, 8'h01);
    @(posedge clock_i) ss_n <= 1'b1;
    pha <= 1'b1;
    clear;
    for (int j = 0; j < 2; j++) begin
      write(8'h61 + j[7:0], 1'b0);
      sl_xfer(8'h18 + j[7:0], q);
      chk(q, 8'h61 + j[7:0]);
      read(8'h18 + j[7:0]);
    end
    end_of_test;
  end
endmodule // smsx_core_tb
bind smsx_core smsx_chk chk (.clock_i, .nrst_i, .enable_i, .master_i,
  .clock_idle_level_select_i, .clock_edge_format_select_i, .fault_detect_en_i,
  .serial_data_port_wr_i, .status_clear_i, .ss_n_i, .done_o, .busy_o, .write_collision_o,
  .mode_fault_o, .sck_o, .sck_oe_o, .mosi_oe_o, .miso_oe_o);
